/* pkg/atc_pkg.sv */
/*
 * Shared constants and carrier types for the conversion trigger and
 * sampling control block: register map, field layout, reset values,
 * trigger source codes and sequencer states.
 * Assumes one synchronous clock domain and a plain register port.
 */
package atc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the register port)
   // ----------------------------------------------------------------
   localparam logic [7:0]  ATC_ADDR_TRIG    = 8'h00;  // Trigger select
   localparam logic [7:0]  ATC_ADDR_SHC     = 8'h04;  // Sample-and-hold control
   localparam logic [7:0]  ATC_ADDR_MODE    = 8'h08;  // Sample-and-hold mode select
   localparam logic [7:0]  ATC_ADDR_CLKDIV  = 8'h0c;  // Conversion clock divider
   localparam logic [7:0]  ATC_ADDR_STATUS  = 8'h10;  // Sequencer status
   localparam logic [7:0]  ATC_ADDR_SSC     = 8'h80;  // First sampling state count
   localparam int          ATC_SSC_NUM      = 19;     // Counts: 0 to 15, L, T, O

   // ----------------------------------------------------------------
   // Field positions and writable masks
   // ----------------------------------------------------------------
   localparam int          ATC_TRIG_MAIN_LSB = 8;     // Main-group code [13:8]
   localparam int          ATC_TRIG_B_LSB    = 0;     // Group-B code [5:0]
   localparam logic [15:0] ATC_TRIG_MASK     = 16'h3f3f;
   localparam int          ATC_SHC_BYP_LSB   = 8;     // Bypass select [10:8]
   localparam logic [15:0] ATC_SHC_MASK      = 16'h07ff;
   localparam int          ATC_SH_CHANNELS   = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] ATC_TRIG_RESET   = 16'h3f3f; // No source in either group
   localparam logic [7:0]  ATC_SSC_RESET    = 8'h0b;    // 11 states
   localparam logic [10:0] ATC_SHC_RESET    = 11'h018;  // Bypass all, 24 states
   localparam logic [7:0]  ATC_SH_TIME_RESET = 8'h18;

   // ----------------------------------------------------------------
   // Trigger source codes
   // ----------------------------------------------------------------
   localparam logic [5:0] ATC_TRG_NONE     = 6'h3f;
   localparam logic [5:0] ATC_TRG_MFT0_A   = 6'h01;
   localparam logic [5:0] ATC_TRG_MFT1_A   = 6'h02;
   localparam logic [5:0] ATC_TRG_MFT2_A   = 6'h03;
   localparam logic [5:0] ATC_TRG_MFT3_A   = 6'h04;
   localparam logic [5:0] ATC_TRG_MFT4_A   = 6'h05;
   localparam logic [5:0] ATC_TRG_MFT6_A   = 6'h06;
   localparam logic [5:0] ATC_TRG_MFT7_A   = 6'h07;
   localparam logic [5:0] ATC_TRG_MFT0_E   = 6'h08;
   localparam logic [5:0] ATC_TRG_M4_CA    = 6'h09;
   localparam logic [5:0] ATC_TRG_M4_CB    = 6'h0a;
   localparam logic [5:0] ATC_TRG_M4_EITHER = 6'h0b;
   localparam logic [5:0] ATC_TRG_M4_BOTH  = 6'h0c;
   localparam logic [5:0] ATC_TRG_M7_CA    = 6'h0d;
   localparam logic [5:0] ATC_TRG_M7_CB    = 6'h0e;
   localparam logic [5:0] ATC_TRG_M7_EITHER = 6'h0f;
   localparam logic [5:0] ATC_TRG_M7_BOTH  = 6'h10;
   localparam logic [5:0] ATC_TRG_EBT0     = 6'h1d;
   localparam logic [5:0] ATC_TRG_EBT2     = 6'h1e;
   localparam logic [5:0] ATC_TRG_PTU_ANY  = 6'h1f;
   localparam logic [5:0] ATC_TRG_PTU0     = 6'h20;
   localparam logic [5:0] ATC_TRG_ELC      = 6'h30;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Timer and event link strobes, one cycle each
   typedef struct packed {
      logic [7:0] mftGenA;     // Channel n general register A event
      logic       mft4Trough;  // Channel 4 complementary PWM trough
      logic       mft7Trough;  // Channel 7 complementary PWM trough
      logic       mft0GenE;    // Channel 0 general register E match
      logic       mft4CmpA;    // Channel 4 converter-start compare A
      logic       mft4CmpB;    // Channel 4 converter-start compare B
      logic       mft7CmpA;    // Channel 7 converter-start compare A
      logic       mft7CmpB;    // Channel 7 converter-start compare B
      logic       ebt0CmpA;    // Eight-bit timer 0 constant A match
      logic       ebt2CmpA;    // Eight-bit timer 2 constant A match
      logic [5:0] ptuGenA;     // Pulse unit channel n register A event
      logic       elcEvent;    // Event link controller output
   } atc_events_t;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } atc_bus_t;

   // Sampling sequencer states
   typedef enum logic [1:0] {
      ATC_SEQ_IDLE = 2'b00,
      ATC_SEQ_SH   = 2'b01,
      ATC_SEQ_CH   = 2'b10
   } atc_seq_t;

endpackage

/* logic/atc_trigger_decode.sv */
/*
 * Trigger source decoder: turns a 6-bit source code and the timer and
 * event link strobes into one start hit for a scan group.
 * Assumes all strobes are synchronous one-cycle pulses.
 */
`timescale 1ns/10ps

module atc_trigger_decode (
   // Selection
   input  wire logic [5:0]          code,
   // Event strobes
   input  wire atc_pkg::atc_events_t events,
   // Result
   output logic                     hit
);

   // ----------------------------------------------------------------
   // Code to event mapping
   // ----------------------------------------------------------------
   always_comb begin
      case (code)
         atc_pkg::ATC_TRG_MFT0_A:    hit = events.mftGenA[0];
         atc_pkg::ATC_TRG_MFT1_A:    hit = events.mftGenA[1];
         atc_pkg::ATC_TRG_MFT2_A:    hit = events.mftGenA[2];
         atc_pkg::ATC_TRG_MFT3_A:    hit = events.mftGenA[3];
         atc_pkg::ATC_TRG_MFT4_A:    hit = events.mftGenA[4] | events.mft4Trough;
         atc_pkg::ATC_TRG_MFT6_A:    hit = events.mftGenA[6];
         atc_pkg::ATC_TRG_MFT7_A:    hit = events.mftGenA[7] | events.mft7Trough;
         atc_pkg::ATC_TRG_MFT0_E:    hit = events.mft0GenE;
         atc_pkg::ATC_TRG_M4_CA:     hit = events.mft4CmpA;
         atc_pkg::ATC_TRG_M4_CB:     hit = events.mft4CmpB;
         atc_pkg::ATC_TRG_M4_EITHER: hit = events.mft4CmpA | events.mft4CmpB;
         atc_pkg::ATC_TRG_M4_BOTH:   hit = events.mft4CmpA & events.mft4CmpB;
         atc_pkg::ATC_TRG_M7_CA:     hit = events.mft7CmpA;
         atc_pkg::ATC_TRG_M7_CB:     hit = events.mft7CmpB;
         atc_pkg::ATC_TRG_M7_EITHER: hit = events.mft7CmpA | events.mft7CmpB;
         atc_pkg::ATC_TRG_M7_BOTH:   hit = events.mft7CmpA & events.mft7CmpB;
         atc_pkg::ATC_TRG_EBT0:      hit = events.ebt0CmpA;
         atc_pkg::ATC_TRG_EBT2:      hit = events.ebt2CmpA;
         atc_pkg::ATC_TRG_PTU_ANY:   hit = |events.ptuGenA;
         atc_pkg::ATC_TRG_PTU0:      hit = events.ptuGenA[0];
         atc_pkg::ATC_TRG_ELC:       hit = events.elcEvent;
         // All-ones and unlisted codes select nothing
         default:                    hit = 1'b0;
      endcase
   end

endmodule

/* logic/atc_control.sv */
/*
 * Conversion start trigger selection and sampling time control.
 * Holds the trigger codes of the main group and group B, the sampling
 * state counts, and the dedicated sample-and-hold settings, and runs a
 * sampling sequencer timed in conversion clock states.
 * Assumes a plain register port with read data one cycle after the
 * read strobe, and a converter core that supplies the channel index.
 */
// The strobed register port and the address map were left to the implementer.
// Overview of operation
// - Main trigger code in bits 13:8, ones none
// - Codes 1-7 pick timer channel register A
// - Codes 8-12 pick channel 0 E, channel 4
// - Codes 13-16 pick channel 7 compares
// - Codes 29-32 pick 8-bit timers, pulse unit
// - Code 48 picks the event link output
// - Group-B code in bits 5:0, same set
// - Sampling time is count times conversion clock
// - Sampling state counts reset to 11
// - Bits 10:8 use or bypass dedicated S/H
// - Bits 7:0 set dedicated S/H time, 4-255; code takes any value 0-255
// - Dedicated S/H time resets to 24
// - Mode bit 0 enables continuous sampling
`timescale 1ns/10ps

module atc_control (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 reset,
   // Register port
   input  wire atc_pkg::atc_bus_t    bus,
   output logic [15:0]               readData,
   // Trigger strobes from timers and event link
   input  wire atc_pkg::atc_events_t events,
   // Converter core side
   input  wire logic [4:0]           chanIdx,
   output logic                      scanStartMain,
   output logic                      scanStartB,
   output logic [2:0]                shTrack,
   output logic                      chanSampling,
   output logic                      samplingDone
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0]                        trigSel;   // Both group codes
      logic [10:0]                        shCtrl;    // Bypass select and S/H time
      logic                               contEn;    // Continuous sampling
      logic [1:0]                         clkDiv;    // Conversion clock divider
      logic [atc_pkg::ATC_SSC_NUM-1:0][7:0] ssc;     // Sampling state counts
      logic [2:0]                         prescale;  // Conversion clock prescaler
      atc_pkg::atc_seq_t                  seq;       // Sequencer state
      logic [7:0]                         seqCount;  // States left in phase
      logic [1:0]                         start;     // Registered start pulses
      logic                               done;      // End of sampling pulse
      logic                               lastGroupB; // Group of the last scan
      logic [15:0]                        rdData;    // Read data register
   } atc_state_t;

   atc_state_t state_reg;    // Registered state
   atc_state_t state_next;   // Next state
   logic [1:0] groupHit;     // Decoded trigger per group
   logic       convTick;     // One conversion clock state elapsed
   logic [4:0] sscIdx;       // Channel index limited to the table
   logic [4:0] rdIdx;        // Sampling count index on the port
   logic       rdIdxValid;   // Port address lies on a count register

   // ----------------------------------------------------------------
   // Trigger decoders, one per scan group
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : gDecode
      atc_trigger_decode uDecode (
         .code   (g == 0 ? state_reg.trigSel[atc_pkg::ATC_TRIG_MAIN_LSB +: 6]
                         : state_reg.trigSel[atc_pkg::ATC_TRIG_B_LSB +: 6]),
         .events (events),
         .hit    (groupHit[g])
      );
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Divider: clock /1, /2, /4, /8 selected by clkDiv
   // Compare is >= so lowering the divider never stalls the tick
   assign convTick  = (state_reg.prescale >=
                       3'((4'h1 << state_reg.clkDiv) - 4'h1));
   assign sscIdx    = (chanIdx < 5'(atc_pkg::ATC_SSC_NUM)) ? chanIdx : 5'h00;
   assign rdIdx     = bus.addr[6:2];
   assign rdIdxValid = bus.addr[7] && (bus.addr[1:0] == 2'h0)
                       && (rdIdx < 5'(atc_pkg::ATC_SSC_NUM));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // One pass computes every field's next value
   always_comb begin
      state_next       = state_reg;
      state_next.start = groupHit;
      state_next.done  = 1'b0;

      // Conversion clock prescaler
      if (convTick) begin
         state_next.prescale = 3'h0;
      end else begin
         state_next.prescale = state_reg.prescale + 3'h1;
      end

      // Register writes; reserved bits are dropped
      if (bus.wr) begin
         if (bus.addr == atc_pkg::ATC_ADDR_TRIG) begin
            state_next.trigSel = bus.wdata & atc_pkg::ATC_TRIG_MASK;
         end else if (bus.addr == atc_pkg::ATC_ADDR_SHC) begin
            state_next.shCtrl = bus.wdata[10:0];
         end else if (bus.addr == atc_pkg::ATC_ADDR_MODE) begin
            state_next.contEn = bus.wdata[0];
         end else if (bus.addr == atc_pkg::ATC_ADDR_CLKDIV) begin
            state_next.clkDiv = bus.wdata[1:0];
         end else if (rdIdxValid) begin
            state_next.ssc[rdIdx] = bus.wdata[7:0];
         end
      end

      // Register reads, answered in the next cycle
      state_next.rdData = 16'h0000;
      if (bus.rd) begin
         if (bus.addr == atc_pkg::ATC_ADDR_TRIG) begin
            state_next.rdData = state_reg.trigSel;
         end else if (bus.addr == atc_pkg::ATC_ADDR_SHC) begin
            state_next.rdData = {5'h00, state_reg.shCtrl};
         end else if (bus.addr == atc_pkg::ATC_ADDR_MODE) begin
            state_next.rdData = {15'h0000, state_reg.contEn};
         end else if (bus.addr == atc_pkg::ATC_ADDR_CLKDIV) begin
            state_next.rdData = {14'h0000, state_reg.clkDiv};
         end else if (bus.addr == atc_pkg::ATC_ADDR_STATUS) begin
            state_next.rdData = {5'h00, state_reg.lastGroupB, state_reg.seq,
                                 state_reg.seqCount};
         end else if (rdIdxValid) begin
            state_next.rdData = {8'h00, state_reg.ssc[rdIdx]};
         end
      end

      // Sampling sequencer
      case (state_reg.seq)
         atc_pkg::ATC_SEQ_IDLE: begin
            // A start while busy is ignored; main group wins a tie
            if (|state_reg.start) begin
               state_next.lastGroupB = !state_reg.start[0];
               if (|state_reg.shCtrl[10:8]) begin
                  state_next.seq      = atc_pkg::ATC_SEQ_SH;
                  state_next.seqCount = state_reg.shCtrl[7:0];
               end else begin
                  state_next.seq      = atc_pkg::ATC_SEQ_CH;
                  state_next.seqCount = state_reg.ssc[sscIdx];
               end
            end
         end
         atc_pkg::ATC_SEQ_SH: begin
            // Dedicated sample-and-hold phase
            if (convTick) begin
               if (state_reg.seqCount <= 8'h01) begin
                  state_next.seq      = atc_pkg::ATC_SEQ_CH;
                  state_next.seqCount = state_reg.ssc[sscIdx];
               end else begin
                  state_next.seqCount = state_reg.seqCount - 8'h01;
               end
            end
         end
         atc_pkg::ATC_SEQ_CH: begin
            // Analog input sampling phase
            if (convTick) begin
               if (state_reg.seqCount <= 8'h01) begin
                  state_next.seq      = atc_pkg::ATC_SEQ_IDLE;
                  state_next.seqCount = 8'h00;
                  state_next.done     = 1'b1;
               end else begin
                  state_next.seqCount = state_reg.seqCount - 8'h01;
               end
            end
         end
         default: begin
            state_next.seq = atc_pkg::ATC_SEQ_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset loads the documented values, all else clears
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg          <= '0;
         state_reg.trigSel  <= atc_pkg::ATC_TRIG_RESET;
         state_reg.shCtrl   <= atc_pkg::ATC_SHC_RESET;
         state_reg.ssc      <= {atc_pkg::ATC_SSC_NUM{atc_pkg::ATC_SSC_RESET}};
         state_reg.seq      <= atc_pkg::ATC_SEQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Starts, done and read data come straight from flops
   assign readData      = state_reg.rdData;
   assign scanStartMain = state_reg.start[0];
   assign scanStartB    = state_reg.start[1];
   assign chanSampling  = (state_reg.seq == atc_pkg::ATC_SEQ_CH);
   assign samplingDone  = state_reg.done;
   // Dedicated circuits track in continuous mode or during their phase
   assign shTrack = state_reg.shCtrl[10:8]
                    & {3{state_reg.contEn || (state_reg.seq == atc_pkg::ATC_SEQ_SH)}};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // ----------------------------------------------------------------
   // Trigger selection
   // ----------------------------------------------------------------
   // No source code: main start stays low
   AST_NONE_QUIET: assert property (
      @(posedge clock) disable iff (reset)
      (state_reg.trigSel[13:8] == atc_pkg::ATC_TRG_NONE) |=> !scanStartMain)
      else $error("main start with no source selected");

   // Channel 4 trough alone starts the main scan
   AST_MFT4_TROUGH: assert property (
      @(posedge clock) disable iff (reset)
      (state_reg.trigSel[13:8] == atc_pkg::ATC_TRG_MFT4_A && events.mft4Trough)
      |=> scanStartMain)
      else $error("channel 4 trough did not start main scan");

   // Both-compare code needs A and B together
   AST_M4_BOTH: assert property (
      @(posedge clock) disable iff (reset)
      (state_reg.trigSel[13:8] == atc_pkg::ATC_TRG_M4_BOTH)
      |=> (scanStartMain == $past(events.mft4CmpA && events.mft4CmpB)))
      else $error("channel 4 both-compare start wrong");

   // Either-compare code takes A or B
   AST_M7_EITHER: assert property (
      @(posedge clock) disable iff (reset)
      (state_reg.trigSel[5:0] == atc_pkg::ATC_TRG_M7_EITHER)
      |=> (scanStartB == $past(events.mft7CmpA || events.mft7CmpB)))
      else $error("channel 7 either-compare start wrong");

   // Any pulse unit channel starts the main scan
   AST_PTU_ANY: assert property (
      @(posedge clock) disable iff (reset)
      (state_reg.trigSel[13:8] == atc_pkg::ATC_TRG_PTU_ANY && |events.ptuGenA)
      |=> scanStartMain)
      else $error("pulse unit event did not start main scan");

   // Event link starts group B
   AST_ELC_B: assert property (
      @(posedge clock) disable iff (reset)
      (state_reg.trigSel[5:0] == atc_pkg::ATC_TRG_ELC && events.elcEvent)
      |=> scanStartB)
      else $error("event link did not start group B scan");

   // ----------------------------------------------------------------
   // Reset values, registers and sequencer
   // ----------------------------------------------------------------
   // First and last counts hold their reset value as reset ends
   AST_SSC_RESET: assert property (
      @(posedge clock)
      $fell(reset) |-> (state_reg.ssc[0] == atc_pkg::ATC_SSC_RESET
                        && state_reg.ssc[atc_pkg::ATC_SSC_NUM-1] == atc_pkg::ATC_SSC_RESET))
      else $error("sampling count reset value wrong");

   // Hold time holds its reset value as reset ends
   AST_SH_RESET: assert property (
      @(posedge clock)
      $fell(reset) |-> (state_reg.shCtrl[7:0] == atc_pkg::ATC_SH_TIME_RESET))
      else $error("sample-and-hold time reset value wrong");

   // Reserved control bits read zero
   AST_SHC_RSVD: assert property (
      @(posedge clock) disable iff (reset)
      $past(bus.rd && bus.addr == atc_pkg::ATC_ADDR_SHC) |-> (readData[15:11] == 5'h00))
      else $error("reserved control bits read nonzero");

   // Setting the mode bit makes the used circuits track
   AST_CONT_TRACK: assert property (
      @(posedge clock) disable iff (reset)
      (bus.wr && bus.addr == atc_pkg::ATC_ADDR_MODE && bus.wdata[0])
      |=> (shTrack == state_reg.shCtrl[10:8]))
      else $error("continuous sampling not tracking");

   // Last channel state ends sampling with one done pulse
   AST_CH_END: assert property (
      @(posedge clock) disable iff (reset)
      (chanSampling && convTick && state_reg.seqCount == 8'h01)
      |=> (samplingDone && !chanSampling))
      else $error("channel sampling did not end on last state");

endmodule

/* test/atc_event_src.sv */
/*
 * Stand-in for the timers and the event link: replays one event
 * pattern as one-cycle strobes when the bench asks for it.
 * Assumes the bench raises fire for exactly one clock.
 */
`timescale 1ns/10ps

module atc_event_src (
   // Clock
   input  wire logic                 clock,
   // Request from the bench
   input  wire atc_pkg::atc_events_t pattern,
   input  wire logic                 fire,
   // Strobes towards the block
   output atc_pkg::atc_events_t      events
);
   // ----------------------------------------------------------------
   // Strobe register
   // ----------------------------------------------------------------
   // Each strobe lasts one cycle, then the lines fall back to quiet
   always_ff @(posedge clock) begin
      events <= fire ? pattern : '0;
   end
endmodule

/* test/tb_atc_control.sv */
/*
 * Self-checking bench for the trigger and sampling control block.
 * Assumes the event stand-in model and the shared package constants.
 */
`timescale 1ns/10ps

module tb_atc_control;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic                 clock   = 1'b0;  // 50 ns clock
   logic                 reset   = 1'b1;  // Synchronous reset
   atc_pkg::atc_bus_t    bus     = '0;    // Register port request
   atc_pkg::atc_events_t pattern = '0;    // Pattern for the stand-in
   logic                 fire    = 1'b0;  // Stand-in request
   logic [4:0]           chanIdx = 5'h03; // Channel being sampled
   logic [15:0]          readData;
   atc_pkg::atc_events_t events;
   logic                 scanStartMain, scanStartB, chanSampling, samplingDone;
   logic [2:0]           shTrack;
   int                   err_total = 0;
   int                   tests_run = 0;
   // Code, expected hit, event pattern
   logic [35:0]          codeTbl [34] = '{
      36'h01_1_010000, 36'h02_1_020000, 36'h03_1_040000, 36'h04_1_080000, 36'h05_1_100000,
      36'h05_1_008000, 36'h06_1_400000, 36'h07_1_800000, 36'h07_1_004000, 36'h08_1_002000,
      36'h09_1_001000, 36'h0a_1_000800, 36'h0a_0_001000, 36'h0b_1_001000, 36'h0b_1_000800,
      36'h0c_0_001000, 36'h0c_1_001800, 36'h0d_1_000400, 36'h0e_1_000200, 36'h0f_1_000200,
      36'h0f_1_000400, 36'h10_0_000400, 36'h10_1_000600, 36'h1d_1_000100, 36'h1e_1_000080,
      36'h1e_0_000100, 36'h1f_1_000010, 36'h1f_1_000040, 36'h20_1_000002, 36'h20_0_000004,
      36'h30_1_000001, 36'h3f_0_ffffff, 36'h11_0_ffffff, 36'h01_0_feffff};

   always #25 clock = ~clock;

   atc_event_src src (.clock(clock), .pattern(pattern), .fire(fire), .events(events));
   atc_control uut (.clock(clock), .reset(reset), .bus(bus), .readData(readData),
      .events(events), .chanIdx(chanIdx), .scanStartMain(scanStartMain),
      .scanStartB(scanStartB), .shTrack(shTrack), .chanSampling(chanSampling),
      .samplingDone(samplingDone));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One-cycle write strobe, then the port goes quiet
   task automatic regWrite(input logic [7:0] addr, input logic [15:0] data);
      @(posedge clock);
      bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus <= '0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic expectReg(input logic [7:0] addr, input logic [15:0] exp);
      @(posedge clock);
      bus <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 check(readData, exp);
   endtask

   // Stand-in strobes appear one edge after the request
   task automatic fireEvents(input logic [23:0] pat);
      @(posedge clock);
      pattern <= atc_pkg::atc_events_t'(pat);
      fire    <= 1'b1;
      @(posedge clock);
      fire    <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic testResetValues;
      expectReg(atc_pkg::ATC_ADDR_TRIG, 16'h3f3f);
      expectReg(atc_pkg::ATC_ADDR_SHC, 16'h0018);
      expectReg(atc_pkg::ATC_ADDR_MODE, 16'h0000);
      expectReg(atc_pkg::ATC_ADDR_SSC, 16'h000b);
      expectReg(8'hc8, 16'h000b);
      expectReg(atc_pkg::ATC_ADDR_CLKDIV, 16'h0000);
      expectReg(atc_pkg::ATC_ADDR_STATUS, 16'h0000);
      $display("Reset value test finished");
   endtask

   task automatic testRegAccess;
      regWrite(atc_pkg::ATC_ADDR_TRIG, 16'hffff);
      expectReg(atc_pkg::ATC_ADDR_TRIG, 16'h3f3f);
      regWrite(atc_pkg::ATC_ADDR_SHC, 16'hffff);
      expectReg(atc_pkg::ATC_ADDR_SHC, 16'h07ff);
      regWrite(atc_pkg::ATC_ADDR_MODE, 16'hffff);
      expectReg(atc_pkg::ATC_ADDR_MODE, 16'h0001);
      regWrite(atc_pkg::ATC_ADDR_CLKDIV, 16'hffff);
      expectReg(atc_pkg::ATC_ADDR_CLKDIV, 16'h0003);
      regWrite(atc_pkg::ATC_ADDR_SSC, 16'hffff);
      expectReg(atc_pkg::ATC_ADDR_SSC, 16'h00ff);
      regWrite(8'h44, 16'hffff);
      expectReg(8'h44, 16'h0000);
      $display("Register access test finished");
   endtask

   // Pass 0: channel phase only, a tick per two clocks, first may come early
   // Pass 1: dedicated hold phase, then channel phase, a tick per clock
   task automatic testSampling;
      int shCnt;
      int chCnt;
      int n;
      regWrite(atc_pkg::ATC_ADDR_MODE, 16'h0000);
      regWrite(8'h8c, 16'h0006);
      regWrite(atc_pkg::ATC_ADDR_TRIG, 16'h303f);
      for (int pass = 0; pass < 2; pass++) begin
         shCnt = 0;
         chCnt = 0;
         regWrite(atc_pkg::ATC_ADDR_CLKDIV, (pass == 0) ? 16'h0001 : 16'h0000);
         regWrite(atc_pkg::ATC_ADDR_SHC, (pass == 0) ? 16'h0009 : 16'h0309);
         fireEvents(24'h000001);
         for (n = 0; n < 100 && samplingDone !== 1'b1; n++) begin
            @(posedge clock);
            #1;
            if (shTrack === 3'b011) shCnt++;
            if (chanSampling === 1'b1) chCnt++;
         end
         if (n >= 100) begin
            err_total++;
            tally_and_finish;
         end
         check({14'h0, chanSampling, samplingDone}, 16'h0001);
         check(shCnt[15:0], (pass == 0) ? 16'h0000 : 16'h0009);
         check(16'((pass == 0) ? (chCnt + 1) / 2 : chCnt), 16'h0006);
         @(posedge clock);
         #1 check({15'h0, samplingDone}, 16'h0000);
      end
      regWrite(atc_pkg::ATC_ADDR_MODE, 16'h0001);
      #1 check({13'h0, shTrack}, 16'h0003);
      regWrite(atc_pkg::ATC_ADDR_MODE, 16'h0000);
      #1 check({13'h0, shTrack}, 16'h0000);
      $display("Sampling test finished");
   endtask

   // Every listed code in both groups, plus wrong and unlisted sources
   task automatic testTriggerCodes;
      logic [5:0] code;
      logic       hit;
      for (int i = 0; i < 34; i++) begin
         for (int g = 0; g < 2; g++) begin
            code = codeTbl[i][33:28];
            hit  = codeTbl[i][24];
            regWrite(atc_pkg::ATC_ADDR_TRIG, (g == 0) ? {2'b00, code, 8'h3f} : {10'h0fc, code});
            fireEvents(codeTbl[i][23:0]);
            #1 check({14'h0, scanStartMain, scanStartB}, 16'h0000);
            @(posedge clock);
            #1 check({14'h0, scanStartMain, scanStartB},
                     {14'h0, hit & (g == 0), hit & (g == 1)});
            @(posedge clock);
            #1 check({14'h0, scanStartMain, scanStartB}, 16'h0000);
         end
      end
      $display("Trigger code test finished");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      testResetValues;
      testRegAccess;
      testSampling;
      testTriggerCodes;
      tally_and_finish;
   end
endmodule
